/* File: piso_shift_register_8bit.sv */
// Parallel-in serial-out shift register with Wishbone control and a two-entry output buffer
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module piso_shift_register_8bit
  import piso_pkg::*;
#(
  parameter int unsigned BUF_WIDTH = 1,
  parameter int unsigned BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_arst_n,
  // Shift register pins
  input  wire logic                  i_shift_clock,
  input  wire logic                  i_clock_enable_n,
  input  wire logic                  i_parallel_load_n,
  input  wire logic                  i_serial_in,
  input  wire logic [STAGES-1:0]     i_parallel_in,
  input  wire logic                  i_clear_n,
  output logic                       o_serial_out,
  // Serial bit stream
  output logic                       o_bit_valid,
  input  wire logic                  i_bit_ready,
  output logic [BUF_WIDTH-1:0]       o_bit_data,
  // Wishbone slave
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [WB_ADDR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [WB_DATA_W-1:0]  i_wb_dat,
  output logic [WB_DATA_W-1:0]       o_wb_dat,
  output logic                       o_wb_ack
);

  // ---------------------------------------------------------------
  // Local widths
  // ---------------------------------------------------------------
  localparam int unsigned PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  // The fill counter needs one value more than the depth
  localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                  rst_meta_reg;
  logic                  rst_sync_reg;
  logic                  rst_n;

  logic [STAGES-1:0]     stage_reg;
  logic [STAGES-1:0]     stage_next;
  logic                  eff_clock;
  logic                  eff_prev_reg;
  logic                  eff_rise;
  logic                  pending_reg;
  logic                  want_advance;
  logic                  advance;
  logic                  overrun_reg;
  logic                  overrun_set;
  logic                  overrun_clr;
  logic [COUNT_W-1:0]    count_reg;

  ctrl_type              ctrl_reg;
  status_type            status;
  logic                  bus_req;
  logic                  bus_write;
  logic                  bus_read;
  logic                  ctrl_write;
  logic                  status_write;
  logic [WB_DATA_W-1:0]  read_data_next;
  bus_state_type         bus_state_reg;

  logic [BUF_WIDTH-1:0]  buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]      wr_ptr_reg;
  logic [PTR_W-1:0]      rd_ptr_reg;
  logic [CNT_W-1:0]      fill_reg;
  logic                  buf_in_valid;
  logic                  buf_in_ready;
  logic                  buf_push;
  logic                  buf_pop;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Release reaches the rest of the design two edges after the pin rises
  assign rst_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // Effective clock
  // ---------------------------------------------------------------
  // Either pin may act as clock, the other as active low enable
  assign eff_clock = i_shift_clock | i_clock_enable_n;

  // Reset high so a clock pin idling high gives no false rise after reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      eff_prev_reg <= 1'b1;
    end else begin
      eff_prev_reg <= eff_clock;
    end
  end

  // A raise of the enable while the clock pin is low would look like a rise here
  assign eff_rise = eff_clock & ~eff_prev_reg;

  // ---------------------------------------------------------------
  // Advance control
  // ---------------------------------------------------------------
  // A rise waits as pending while software holds or the buffer is full
  // Clear beats the clock: no advance, no waiting rise and no push while it is low
  assign want_advance = eff_rise | pending_reg;
  assign advance      = want_advance & i_clear_n & ~ctrl_reg.hold & (~ctrl_reg.stream_en | buf_in_ready);
  assign overrun_set  = eff_rise & pending_reg & i_clear_n & ~advance;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= want_advance & i_clear_n & ~advance;
    end
  end

  // ---------------------------------------------------------------
  // Stage next value
  // ---------------------------------------------------------------
  // A shift moves each stage up one, the serial input entering stage 0
  always_comb begin
    stage_next = stage_reg;
    if (advance) begin
      if (!i_parallel_load_n) begin
        stage_next = i_parallel_in;
      end else begin
        stage_next = {stage_reg[STAGES-2:0], i_serial_in};
      end
    end
  end

  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  // Clear acts without the clock and wins over everything
  always_ff @(posedge i_mclk or negedge rst_n or negedge i_clear_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
    end else if (!i_clear_n) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Only the last stage leaves the block
  assign o_serial_out = stage_reg[STAGES-1];

  // ---------------------------------------------------------------
  // Advance counter and overrun flag
  // ---------------------------------------------------------------
  // Counts every advance and wraps at the top
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (advance) begin
      count_reg <= count_reg + COUNT_W'(1);
    end
  end

  // Software clears overrun by writing one to its bit
  assign overrun_clr = status_write & i_wb_dat[STAT_OVR_BIT];

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (overrun_set) begin
      overrun_reg <= 1'b1;
    end else if (overrun_clr) begin
      overrun_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------
  // Full at two entries; a rise then waits as pending
  assign buf_in_valid = advance & ctrl_reg.stream_en;
  assign buf_in_ready = (fill_reg != CNT_W'(BUF_DEPTH));
  assign buf_push     = buf_in_valid & buf_in_ready;
  assign o_bit_valid  = (fill_reg != '0);
  assign buf_pop      = o_bit_valid & i_bit_ready;
  assign o_bit_data   = buf_mem[rd_ptr_reg];

  // Each entry holds the serial output level right after the advance
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
    end else if (buf_push) begin
      buf_mem[wr_ptr_reg] <= BUF_WIDTH'(stage_next[STAGES-1]);
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
    end else if (buf_push) begin
      wr_ptr_reg <= (wr_ptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_reg + PTR_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= '0;
    end else if (buf_pop) begin
      rd_ptr_reg <= (rd_ptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_reg + PTR_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      fill_reg <= '0;
    end else begin
      // A push and a pop in one cycle leave the fill level as it is
      case ({buf_push, buf_pop})
        2'b10: begin
          fill_reg <= fill_reg + CNT_W'(1);
        end
        2'b01: begin
          fill_reg <= fill_reg - CNT_W'(1);
        end
        default: begin
          fill_reg <= fill_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // A request is taken once, in an idle cycle
  assign bus_req      = i_wb_cyc & i_wb_stb & (bus_state_reg == BUS_IDLE);
  assign bus_write    = bus_req & i_wb_we;
  assign bus_read     = bus_req & ~i_wb_we;
  assign ctrl_write   = bus_write & (i_wb_adr == CTRL_ADDR) & i_wb_sel[0];
  assign status_write = bus_write & (i_wb_adr == STATUS_ADDR) & i_wb_sel[0];

  // ---------------------------------------------------------------
  // Bus state
  // ---------------------------------------------------------------

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_state_reg <= BUS_IDLE;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // Ack lasts one cycle; a request still up then is taken again in the idle cycle after it
  assign o_wb_ack = (bus_state_reg == BUS_ACK);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg.stream_en <= CTRL_STREAM_RST;
      ctrl_reg.hold      <= CTRL_HOLD_RST;
    end else if (ctrl_write) begin
      ctrl_reg.stream_en <= i_wb_dat[CTRL_STREAM_BIT];
      ctrl_reg.hold      <= i_wb_dat[CTRL_HOLD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  // Clear level is shown so software can tell why the stages read zero
  always_comb begin
    status.serial_out   = stage_reg[STAGES-1];
    status.pending      = pending_reg;
    status.overrun      = overrun_reg;
    status.clear_active = ~i_clear_n;
    status.count        = count_reg;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data captured at request, unmapped addresses read zero
  always_comb begin
    read_data_next = '0;
    case (i_wb_adr)
      CTRL_ADDR: begin
        read_data_next[CTRL_STREAM_BIT] = ctrl_reg.stream_en;
        read_data_next[CTRL_HOLD_BIT]   = ctrl_reg.hold;
      end
      STATUS_ADDR: begin
        read_data_next[STAT_SOUT_BIT]             = status.serial_out;
        read_data_next[STAT_PEND_BIT]             = status.pending;
        read_data_next[STAT_OVR_BIT]              = status.overrun;
        read_data_next[STAT_CLEAR_BIT]            = status.clear_active;
        read_data_next[STAT_COUNT_LSB +: COUNT_W] = status.count;
      end
      default: begin
        read_data_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_dat <= '0;
    end else if (bus_read) begin
      o_wb_dat <= read_data_next;
    end
  end

endmodule

/* File: piso_pkg.sv */
// Constants, register map and carrier types for the parallel-in serial-out shift register
// How it works
// - Eight stages, first stage to last stage, all updated together on one advance of the effective clock.
// - A low parallel load select at an effective clock rise copies the whole parallel word into the stages.
// - On a load, parallel input bits 0 to 7 land in stages 0 to 7 and the serial input is ignored.
// - A high load select at an effective clock rise puts the serial input in stage 0 and moves every other stage up one.
// - The last stage drives the serial output, which may feed the serial input of a following register.
// - The effective clock is the OR of the clock pin and the active low enable pin, so it rises when either pin rises while the other is low.
// - The clock pin and the enable pin are interchangeable, since only their OR is used.
// - The stages hold while no effective clock rise is new or left pending by hold or a full buffer.
// - A low clear input zeroes every stage at once without a clock and beats every other input.
package piso_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned STAGES       = 8;
  localparam int unsigned WB_ADDR_W    = 8;
  localparam int unsigned WB_DATA_W    = 32;
  localparam int unsigned COUNT_W      = 8;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  STATUS_ADDR  = 8'h04;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_STREAM_BIT  = 0;
  localparam int unsigned CTRL_HOLD_BIT    = 1;
  localparam int unsigned STAT_SOUT_BIT    = 0;
  localparam int unsigned STAT_PEND_BIT    = 1;
  localparam int unsigned STAT_OVR_BIT     = 2;
  localparam int unsigned STAT_CLEAR_BIT   = 3;
  localparam int unsigned STAT_COUNT_LSB   = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        CTRL_STREAM_RST  = 1'h0;
  localparam logic        CTRL_HOLD_RST    = 1'h0;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic hold;
    logic stream_en;
  } ctrl_type;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic               clear_active;
    logic               overrun;
    logic               pending;
    logic               serial_out;
  } status_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_type;

endpackage

/* File: pin_ctl_model.sv */
// Controlling logic model: clock pulses on either pin, gated
`timescale 1ns/100ps
module pin_ctl_model (
  // Clock and commands
  input  wire logic i_mclk,
  input  wire logic i_go,
  input  wire logic i_swap,
  input  wire logic i_gate,
  // Register pins
  output logic      o_clk_pin,
  output logic      o_en_pin
);
  logic low_reg = 1'b0;
  // Idle high, so the gate only moves while the clock role pin is high
  always_ff @(posedge i_mclk) begin
    low_reg <= i_go;
  end
  assign o_clk_pin = i_swap ? i_gate : !low_reg;
  assign o_en_pin  = i_swap ? !low_reg : i_gate;
endmodule

/* File: piso_checker.sv */
// Concurrent checks on the shift pins, bit buffer and bus
`timescale 1ns/100ps
module piso_checker
  import piso_pkg::*;
#(
  parameter int unsigned BUF_WIDTH = 1
) (
  // Clock and reset
  input wire logic                 i_mclk,
  input wire logic                 i_arst_n,
  // Shift pins
  input wire logic                 i_shift_clock,
  input wire logic                 i_clock_enable_n,
  input wire logic                 i_parallel_load_n,
  input wire logic [STAGES-1:0]    i_parallel_in,
  input wire logic                 i_clear_n,
  input wire logic                 o_serial_out,
  // Bit stream
  input wire logic                 o_bit_valid,
  input wire logic                 i_bit_ready,
  input wire logic [BUF_WIDTH-1:0] o_bit_data,
  // Bus
  input wire logic                 i_wb_cyc,
  input wire logic                 i_wb_stb,
  input wire logic                 i_wb_we,
  input wire logic [WB_ADDR_W-1:0] i_wb_adr,
  input wire logic [WB_DATA_W-1:0] o_wb_dat,
  input wire logic                 o_wb_ack
);
  logic eff;
  assign eff = i_shift_clock | i_clock_enable_n;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  clear_zero_a: assert property (!i_clear_n |-> !o_serial_out)
    else $error("output not zero in clear");
  stall_hold_a: assert property (i_clear_n && !i_wb_cyc && eff && $past(eff) && !o_bit_valid
    |=> !i_clear_n || $stable(o_serial_out)) else $error("moved without a rise");
  load_last_a: assert property (eff && !$past(eff) && !i_parallel_load_n && i_clear_n
    && !o_bit_valid |=> o_serial_out == $past(i_parallel_in[STAGES-1])) else $error("bad load");
  ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  unmapped_zero_a: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr != CTRL_ADDR
    && i_wb_adr != STATUS_ADDR) |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  buf_hold_a: assert property (o_bit_valid && !i_bit_ready |=> o_bit_valid && $stable(o_bit_data))
    else $error("entry lost in stall");
  buf_bit_a: assert property ($rose(o_bit_valid) |-> o_bit_data[0] == o_serial_out)
    else $error("pushed bit differs");
  cover property (eff && !$past(eff) && !i_parallel_load_n);
  cover property (o_wb_ack);
  cover property (o_bit_valid && !i_bit_ready);
endmodule
bind piso_shift_register_8bit piso_checker #(.BUF_WIDTH(BUF_WIDTH)) piso_checker_inst (.i_mclk, .i_arst_n,
  .i_shift_clock, .i_clock_enable_n, .i_parallel_load_n, .i_parallel_in, .i_clear_n, .o_serial_out,
  .o_bit_valid, .i_bit_ready, .o_bit_data, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack);

/* File: testbench.sv */
// Self-checking bench for the parallel-in serial-out shift register
`timescale 1ns/100ps
module testbench;
  import piso_pkg::*;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, go = 1'b0, swap = 1'b0, gate = 1'b0, stall = 1'b0;
  logic i_parallel_load_n = 1'b1, i_serial_in = 1'b0, i_clear_n = 1'b1, i_bit_ready = 1'b0;
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0] i_parallel_in = 8'h00, i_wb_adr = 8'h00, exp_q = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, rd;
  logic q[$];
  wire logic sclk, en_n, o_serial_out, o_bit_valid, o_wb_ack;
  wire logic [0:0] o_bit_data;
  wire logic [31:0] o_wb_dat;
  int fails = 0, compares = 0, adv_cnt = 0;
  pin_ctl_model pin_ctl_model_inst (.i_mclk, .i_go(go), .i_swap(swap), .i_gate(gate), .o_clk_pin(sclk),
    .o_en_pin(en_n));
  piso_shift_register_8bit piso_shift_register_8bit_inst (.i_mclk, .i_arst_n, .i_shift_clock(sclk),
    .i_clock_enable_n(en_n), .i_parallel_load_n, .i_serial_in, .i_parallel_in, .i_clear_n, .o_serial_out,
    .o_bit_valid, .i_bit_ready, .o_bit_data, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack);
  // --------
  // Helpers
  // --------
  initial forever #12.5 i_mclk = ~i_mclk;
  function automatic logic [7:0] nxt(logic [7:0] v, logic ld_n, logic [7:0] w, logic s);
    return ld_n ? {v[6:0], s} : w;
  endfunction
  task automatic test_done;
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic adv(input logic ld_n, input logic [7:0] w, input logic s);
    i_parallel_load_n <= ld_n;
    i_parallel_in <= w;
    i_serial_in <= s;
    go <= 1'b1;
    @(posedge i_mclk) go <= 1'b0;
    repeat (3) @(posedge i_mclk);
    if (!gate && !stall && i_clear_n) begin
      exp_q = nxt(exp_q, ld_n, w, s);
      adv_cnt++;
    end
    @(negedge i_mclk) chk_bit(o_serial_out, exp_q[7]);
    @(posedge i_mclk);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_sel <= s;
    i_wb_dat <= d;
    // Ack seen settled mid-cycle is sampled high at the next rising edge
    while (o_wb_ack !== 1'b1) @(negedge i_mclk);
    @(posedge i_mclk);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_mclk);
  endtask
  // --------
  // Tests
  // --------
  initial begin
    repeat (5000) @(posedge i_mclk);
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(32'h27f3));
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    for (int k = 0; k < 6; k++) begin
      adv(1'b0, k == 0 ? 8'h80 : k == 1 ? 8'h7F : 8'($urandom), 1'($urandom));
      repeat (8) adv(1'b1, 8'($urandom), 1'($urandom));
      if (k == 3) swap <= 1'b1;
    end
    gate <= 1'b1;
    @(posedge i_mclk);
    adv(1'b0, ~exp_q, 1'b1);
    adv(1'b1, 8'h00, ~exp_q[7]);
    gate <= 1'b0;
    swap <= 1'b0;
    adv(1'b0, 8'hFF, 1'b1);
    i_clear_n <= 1'b0;
    #2 chk_bit(o_serial_out, 1'b0);
    exp_q = 8'h00;
    @(posedge i_mclk);
    adv(1'b0, 8'hFF, 1'b1);
    i_clear_n <= 1'b1;
    repeat (8) adv(1'b1, 8'hFF, 1'b0);
    wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
    chk_bit(rd[STAT_SOUT_BIT], exp_q[7]);
    chk_word(32'(rd[STAT_COUNT_LSB +: COUNT_W]), 32'(adv_cnt[7:0]));
    wb(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 4'hF, 32'h0);
    chk_word(rd, 32'h0);
    wb(1'b1, CTRL_ADDR, 4'hE, 32'h3);
    wb(1'b0, CTRL_ADDR, 4'hF, 32'h0);
    chk_word(rd, 32'h0);
    wb(1'b1, CTRL_ADDR, 4'h1, 32'h2);
    stall = 1'b1;
    adv(1'b1, 8'h00, 1'b0);
    adv(1'b1, 8'h00, 1'b1);
    wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
    chk_bit(rd[STAT_PEND_BIT], 1'b1);
    chk_bit(rd[STAT_OVR_BIT], 1'b1);
    wb(1'b1, STATUS_ADDR, 4'h1, 32'h4);
    stall = 1'b0;
    wb(1'b1, CTRL_ADDR, 4'h1, 32'h0);
    exp_q = nxt(exp_q, 1'b1, 8'h00, 1'b1);
    adv_cnt++;
    wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
    chk_word(rd, {16'h0000, 8'(adv_cnt), 7'h00, exp_q[7]});
    wb(1'b1, CTRL_ADDR, 4'h1, 32'h1);
    repeat (2) begin
      adv(1'b1, 8'h00, 1'($urandom));
      q.push_back(exp_q[7]);
    end
    stall = 1'b1;
    adv(1'b1, 8'h00, 1'b1);
    wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
    chk_bit(rd[STAT_PEND_BIT], 1'b1);
    stall = 1'b0;
    exp_q = nxt(exp_q, 1'b1, 8'h00, 1'b1);
    adv_cnt++;
    q.push_back(exp_q[7]);
    i_bit_ready <= 1'b1;
    for (int n = 0; n < 30 && q.size() > 0; n++) begin
      @(negedge i_mclk);
      if (o_bit_valid === 1'b1) chk_bit(o_bit_data[0], q.pop_front());
    end
    chk_word(32'(q.size()), 32'h0);
    chk_bit(o_serial_out, exp_q[7]);
    @(posedge i_mclk);
    wb(1'b1, CTRL_ADDR, 4'hF, 32'h0);
    test_done();
  end
endmodule
